// file: rtl/dacctl_pkg.sv
package dacctl_pkg;

  // ****************************************
  // register map (byte addresses on the bus)
  // ****************************************
  localparam logic [3:0] DACCTL_OFS_CTRL   = 4'h0;   // control_a_reg
  localparam logic [3:0] DACCTL_OFS_DATA_L = 4'h8;   // data_low_byte (index 2)
  localparam logic [3:0] DACCTL_OFS_DATA_H = 4'hC;   // data_high_byte (index 3)
  localparam logic [3:0] DACCTL_OFS_STAT   = 4'h4;   // status

  // control field positions
  localparam int DACCTL_BIT_ENABLE   = 0;
  localparam int DACCTL_BIT_OUTBUF   = 6;
  localparam int DACCTL_BIT_KEEP_RUNNING_IN_STANDBY = 7;
  // data low byte field position
  localparam int DACCTL_DATA_LOW_BYTE_LSB    = 6;
  localparam logic [7:0] DACCTL_CTRL_RST = 8'h00;
  localparam logic [9:0] DACCTL_DATA_RST = 10'h000;
  localparam int DACCTL_DATA_W = 10;

  // start-up time after standby exit
  localparam int DACCTL_STARTUP_NS  = 1000;
  localparam int DACCTL_CLK_NS      = 25;
  localparam int DACCTL_STARTUP_CYC = (DACCTL_STARTUP_NS + DACCTL_CLK_NS - 1) / DACCTL_CLK_NS;

  typedef enum logic [1:0] {DACCTL_OFF, DACCTL_WARM, DACCTL_RUN} dacctl_state_t;

  // wishbone request and answer
  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dacctl_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } dacctl_wb_rsp_t;

  // analogue core controls
  typedef struct packed {
    logic       core_on;
    logic       buf_on;
    logic       int_out_valid;
    logic       convert;
    logic [9:0] code;
  } dacctl_ana_t;

endpackage

// file: rtl/dacctl_sync.sv
`timescale 1ns/10ps
// ****************************************
// two flop synchroniser
// ****************************************
module dacctl_sync
  import dacctl_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // level in and out
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic s1;
    logic s2;
  } dacctl_sync_st_t;

  dacctl_sync_st_t st_reg;
  dacctl_sync_st_t st_next;

  // shift the level through both stages
  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  // register the stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;

endmodule

// file: rtl/dacctl_top.sv
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
// ****************************************
// converter control with wishbone slave
// ****************************************
module dacctl_top
  import dacctl_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic             WB_ACK_O,
  output logic [31:0]      WB_DAT_O,
  // sleep requests from the power controller
  input  wire logic        STANDBY_SLEEP,
  input  wire logic        POWERDOWN_SLEEP,
  // analogue core and output buffer
  output logic             CORE_ON,
  output logic             BUF_ON,
  output logic             INT_OUT_VALID,
  output logic             CONVERT,
  output logic [9:0]       CODE
);

  // ****************************************
  // reset release and input synchronisers
  // ****************************************
  logic rst_s1;
  logic rst_s2;
  logic stby_s;
  logic pdn_s;

  // release reset through two flops
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  dacctl_sync u_sync_stby (
    .clk   (MCLK),
    .rst_n (rst_s2),
    .d     (STANDBY_SLEEP),
    .q     (stby_s)
  );

  dacctl_sync u_sync_pdn (
    .clk   (MCLK),
    .rst_n (rst_s2),
    .d     (POWERDOWN_SLEEP),
    .q     (pdn_s)
  );

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic          ack;
    logic [31:0]   rdat;
    logic [7:0]    ctrl;
    logic [9:0]    data;
    logic          pending;
    logic          convert;
    logic [9:0]    code;
    logic [7:0]    warm_cnt;
    dacctl_state_t fsm;
    logic          core_on;
    logic          buf_on;
  } dacctl_st_t;

  dacctl_st_t st_reg;
  dacctl_st_t st_next;

  dacctl_wb_req_t req;
  logic           wr_acc;
  logic           rd_acc;
  logic           en_bit;
  logic           sleep_off;
  logic           hi_wr;

  assign req     = '{WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I};
  assign wr_acc  = req.cyc && req.stb && req.we && !st_reg.ack;
  assign rd_acc  = req.cyc && req.stb && !req.we && !st_reg.ack;
  assign en_bit  = st_reg.ctrl[DACCTL_BIT_ENABLE];
  // standby without keep-running, or any power-down, stops the core
  assign sleep_off = pdn_s || (stby_s && !st_reg.ctrl[DACCTL_BIT_KEEP_RUNNING_IN_STANDBY]);
  assign hi_wr   = wr_acc && req.adr == DACCTL_OFS_DATA_H && req.sel[0];

  // next state
  always_comb begin
    st_next         = st_reg;
    st_next.ack     = 1'b0;
    st_next.convert = 1'b0;
    // bus answer one cycle after the request
    if (wr_acc || rd_acc) begin
      st_next.ack = 1'b1;
    end
    // register writes, low lane only
    if (wr_acc && req.sel[0]) begin
      case (req.adr)
        DACCTL_OFS_CTRL: begin
          st_next.ctrl = {req.dat[7:6], 5'b0_0000, req.dat[0]};
        end
        DACCTL_OFS_DATA_L: begin
          st_next.data[1:0] = req.dat[DACCTL_DATA_LOW_BYTE_LSB +: 2];
        end
        DACCTL_OFS_DATA_H: begin
          st_next.data[9:2] = req.dat[7:0];
        end
        default: begin
        end
      endcase
    end
    // read data
    if (rd_acc) begin
      case (req.adr)
        DACCTL_OFS_CTRL:   st_next.rdat = {24'h00_0000, st_reg.ctrl};
        DACCTL_OFS_DATA_L: st_next.rdat = {24'h00_0000, st_reg.data[1:0], 6'b00_0000};
        DACCTL_OFS_DATA_H: st_next.rdat = {24'h00_0000, st_reg.data[9:2]};
        DACCTL_OFS_STAT:   st_next.rdat = {27'h000_0000, st_reg.pending,
                                           st_reg.buf_on, st_reg.core_on, 2'(st_reg.fsm)};
        default:           st_next.rdat = 32'h0000_0000;
      endcase
    end
    // a high-byte write requests a conversion
    if (hi_wr) begin
      st_next.pending = 1'b1;
    end
    // converter power sequencing
    case (st_reg.fsm)
      DACCTL_OFF: begin
        st_next.core_on  = 1'b0;
        st_next.buf_on   = 1'b0;
        st_next.warm_cnt = 8'(DACCTL_STARTUP_CYC);
        if (en_bit && !sleep_off) begin
          st_next.fsm     = DACCTL_WARM;
          st_next.core_on = 1'b1;
        end
      end
      DACCTL_WARM: begin
        st_next.core_on = 1'b1;
        st_next.buf_on  = st_reg.ctrl[DACCTL_BIT_OUTBUF];
        // power drops on the same edge as the state, so OFF never shows a live core
        if (!en_bit || sleep_off) begin
          st_next.fsm     = DACCTL_OFF;
          st_next.core_on = 1'b0;
          st_next.buf_on  = 1'b0;
        end else if (st_reg.warm_cnt == 8'h01) begin
          st_next.fsm = DACCTL_RUN;
        end else begin
          st_next.warm_cnt = st_reg.warm_cnt - 8'h01;
        end
      end
      DACCTL_RUN: begin
        st_next.core_on = 1'b1;
        st_next.buf_on  = st_reg.ctrl[DACCTL_BIT_OUTBUF];
        // leaving run switches core and buffer off together with the state
        if (!en_bit || sleep_off) begin
          st_next.fsm     = DACCTL_OFF;
          st_next.core_on = 1'b0;
          st_next.buf_on  = 1'b0;
        end else if (st_reg.pending || hi_wr) begin
          st_next.convert = 1'b1;
          st_next.pending = 1'b0;
          st_next.code    = hi_wr ? {req.dat[7:0], st_next.data[1:0]} : st_reg.data;
        end
      end
      default: begin
        // an illegal state falls back to a powered-down core
        st_next.fsm     = DACCTL_OFF;
        st_next.core_on = 1'b0;
        st_next.buf_on  = 1'b0;
      end
    endcase
  end

  // register state
  always_ff @(posedge MCLK or negedge rst_s2) begin
    if (!rst_s2) begin
      st_reg          <= '0;
      st_reg.ctrl     <= DACCTL_CTRL_RST;
      st_reg.data     <= DACCTL_DATA_RST;
      st_reg.code     <= DACCTL_DATA_RST;
      st_reg.fsm      <= DACCTL_OFF;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign WB_ACK_O      = st_reg.ack;
  assign WB_DAT_O      = st_reg.rdat;
  assign CORE_ON       = st_reg.core_on;
  assign BUF_ON        = st_reg.buf_on;
  assign INT_OUT_VALID = st_reg.core_on;
  assign CONVERT       = st_reg.convert;
  assign CODE          = st_reg.code;

  // ****************************************
  // checks
  // ****************************************
  AST_ENABLE_ON: assert property (@(posedge MCLK) disable iff (!rst_s2)
    (st_reg.fsm == DACCTL_OFF && en_bit && !sleep_off) |=> CORE_ON)
    else $error("converter not switched on after enable");

  AST_DISABLE_OFF: assert property (@(posedge MCLK) disable iff (!rst_s2)
    (st_reg.fsm != DACCTL_OFF && !en_bit) |=> !CORE_ON && !BUF_ON)
    else $error("converter still on after disable");

  AST_WRITE_CONVERTS: assert property (@(posedge MCLK) disable iff (!rst_s2)
    (st_reg.fsm == DACCTL_RUN && en_bit && !sleep_off && hi_wr)
      |=> CONVERT && CODE[9:2] == $past(req.dat[7:0]))
    else $error("data write did not convert at once");

  AST_NO_CONVERT_OFF: assert property (@(posedge MCLK) disable iff (!rst_s2)
    (st_reg.fsm != DACCTL_RUN) |=> !CONVERT)
    else $error("conversion while converter not running");

  AST_DEFERRED: assert property (@(posedge MCLK) disable iff (!rst_s2)
    (st_reg.fsm == DACCTL_RUN && st_reg.pending && !hi_wr && en_bit && !sleep_off)
      |=> CONVERT && CODE == $past(st_reg.data))
    else $error("deferred conversion lost held value");

  AST_BUF_GATE: assert property (@(posedge MCLK) disable iff (!rst_s2)
    BUF_ON |-> CORE_ON && st_reg.fsm != DACCTL_OFF)
    else $error("buffer on without converter");

  AST_POWERDOWN: assert property (@(posedge MCLK) disable iff (!rst_s2)
    pdn_s |=> !CORE_ON && !BUF_ON && st_reg.fsm == DACCTL_OFF)
    else $error("converter on during power-down");

  AST_STARTUP: assert property (@(posedge MCLK) disable iff (!rst_s2)
    $rose(CORE_ON) |-> !CONVERT [*8])
    else $error("conversion before start-up time");

  AST_STANDBY_KEEP: assert property (@(posedge MCLK) disable iff (!rst_s2)
    (st_reg.fsm == DACCTL_RUN && en_bit && stby_s && !pdn_s
      && st_reg.ctrl[DACCTL_BIT_KEEP_RUNNING_IN_STANDBY]) |=> CORE_ON)
    else $error("converter stopped in standby despite keep-running");

  // standby without keep-running takes core and buffer down together
  AST_STANDBY_STOP: assert property (@(posedge MCLK) disable iff (!rst_s2)
    (st_reg.fsm != DACCTL_OFF && stby_s && !st_reg.ctrl[DACCTL_BIT_KEEP_RUNNING_IN_STANDBY])
      |=> !CORE_ON && !BUF_ON && st_reg.fsm == DACCTL_OFF)
    else $error("converter kept running in standby without keep-running");

  // in steady run the buffer tracks its control bit
  AST_BUF_FOLLOW: assert property (@(posedge MCLK) disable iff (!rst_s2)
    (st_reg.fsm == DACCTL_RUN && en_bit && !sleep_off)
      |=> BUF_ON == $past(st_reg.ctrl[DACCTL_BIT_OUTBUF]))
    else $error("buffer does not follow its control bit");

  // a clear buffer bit leaves the pin to other users
  AST_BUF_IDLE: assert property (@(posedge MCLK) disable iff (!rst_s2)
    !st_reg.ctrl[DACCTL_BIT_OUTBUF] |=> !BUF_ON)
    else $error("buffer on with its control bit clear");

  // every wake-up starts from a full start-up count
  AST_WARM_LOAD: assert property (@(posedge MCLK) disable iff (!rst_s2)
    (st_reg.fsm == DACCTL_OFF)
      |=> st_reg.fsm == DACCTL_OFF || st_reg.warm_cnt == 8'(DACCTL_STARTUP_CYC))
    else $error("warm-up did not start from the full count");

  // the count steps down by one each cycle of warm-up
  AST_WARM_COUNT: assert property (@(posedge MCLK) disable iff (!rst_s2)
    (st_reg.fsm == DACCTL_WARM && st_reg.warm_cnt != 8'h01 && en_bit && !sleep_off)
      |=> st_reg.warm_cnt == $past(st_reg.warm_cnt) - 8'h01)
    else $error("warm-up count skipped a step");

  // no run before the count is spent
  AST_WARM_HOLD: assert property (@(posedge MCLK) disable iff (!rst_s2)
    (st_reg.fsm == DACCTL_WARM && st_reg.warm_cnt != 8'h01) |=> st_reg.fsm != DACCTL_RUN)
    else $error("run entered before start-up time");

  // a data write while not running is kept for later
  AST_PENDING_SET: assert property (@(posedge MCLK) disable iff (!rst_s2)
    (hi_wr && st_reg.fsm != DACCTL_RUN) |=> st_reg.pending)
    else $error("deferred conversion request lost");

  // the data word moves only on a data write
  AST_DATA_KEEP: assert property (@(posedge MCLK) disable iff (!rst_s2)
    !(wr_acc && req.sel[0] && (req.adr == DACCTL_OFS_DATA_L || req.adr == DACCTL_OFS_DATA_H))
      |=> $stable(st_reg.data))
    else $error("data word changed without a data write");

  // control moves only on a control write
  AST_CTRL_KEEP: assert property (@(posedge MCLK) disable iff (!rst_s2)
    !(wr_acc && req.sel[0] && req.adr == DACCTL_OFS_CTRL) |=> $stable(st_reg.ctrl))
    else $error("control changed without a control write");

  // internal output is valid exactly while the core is sequenced on
  AST_INT_OUT: assert property (@(posedge MCLK) disable iff (!rst_s2)
    INT_OUT_VALID == (st_reg.fsm != DACCTL_OFF))
    else $error("internal output valid does not match core state");

endmodule

// file: tb/dacctl_core_model.sv
`timescale 1ns/10ps
// ****
// converter core, buffer and pin model
// ****
module dacctl_core_model
  import dacctl_pkg::*;
(
  // clock
  input  wire logic       clk,
  // controls from the block
  input  wire logic       core_on,
  input  wire logic       buf_on,
  input  wire logic       convert,
  input  wire logic [9:0] code,
  // held level and pin
  output logic [9:0]      level = '0,
  output logic [9:0]      pin,
  output int              conv_cnt = 0
);
  // a start is honoured only while powered
  always @(posedge clk) begin
    if (convert && core_on) begin
      level <= code;
      conv_cnt <= conv_cnt + 1;
    end
  end
  // an unbuffered pin shows the inverted level
  assign pin = buf_on ? level : ~level;
endmodule

// file: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import dacctl_pkg::*;
  // ****
  // signals
  // ****
  logic           MCLK = 1'b0;
  logic           RST_N = 1'b0;
  logic           sb = 1'b0;
  logic           pd = 1'b0;
  dacctl_wb_req_t req = '0;
  logic [31:0]    dout;
  logic [31:0]    rd;
  logic           ack;
  logic           core_on;
  logic           buf_on;
  logic           int_ok;
  logic           conv;
  logic [9:0]     code;
  logic [9:0]     lvl;
  logic [9:0]     pin;
  logic [9:0]     d;
  logic [7:0]     cv;
  int             cnv_cnt;
  int             c;
  int             num_errors = 0;
  int             cmp_count = 0;
  dacctl_top u_dacctl_top (.MCLK(MCLK), .RST_N(RST_N), .WB_CYC_I(req.cyc), .WB_STB_I(req.stb),
    .WB_WE_I(req.we), .WB_ADR_I(req.adr), .WB_SEL_I(req.sel), .WB_DAT_I(req.dat),
    .WB_ACK_O(ack), .WB_DAT_O(dout), .STANDBY_SLEEP(sb), .POWERDOWN_SLEEP(pd),
    .CORE_ON(core_on), .BUF_ON(buf_on), .INT_OUT_VALID(int_ok), .CONVERT(conv), .CODE(code));
  dacctl_core_model u_dacctl_core_model (.clk(MCLK), .core_on(core_on), .buf_on(buf_on),
    .convert(conv), .code(code), .level(lvl), .pin(pin), .conv_cnt(cnv_cnt));
  // clock
  initial begin
    forever #12.5 MCLK = ~MCLK;
  end
  // ****
  // tasks
  // ****
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge MCLK);
    req <= '{1'b1, 1'b1, w, a, 4'h1, v};
    do begin
      @(posedge MCLK);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = dout;
    req <= '0;
    if (ack !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
  endtask
  task automatic wait_cnv(input int c0);
    int n;
    n = 0;
    while (cnv_cnt == c0 && n < 100) begin
      @(posedge MCLK);
      n++;
    end
    if (cnv_cnt == c0) begin
      num_errors++;
      wrap_up();
    end
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    void'($urandom(89719));
    repeat (20) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    wb(1'b0, DACCTL_OFS_CTRL, 32'h0);
    chk("ctrl_reset", rd, 32'h0);
    chk("core_reset", core_on, 1'b0);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", rd, 32'h0);
    // first pass deferred, then enabled with corner codes
    for (int i = 0; i < 6; i++) begin
      d = (i == 1) ? 10'h000 : (i == 2) ? 10'h3FF : 10'($urandom);
      c = cnv_cnt;
      wb(1'b1, DACCTL_OFS_DATA_L, {24'h0, d[1:0], 6'h00});
      wb(1'b1, DACCTL_OFS_DATA_H, {24'h0, d[9:2]});
      repeat (3) @(posedge MCLK);
      if (i == 0) begin
        chk("no_conv_off", cnv_cnt, c);
        wb(1'b1, DACCTL_OFS_CTRL, 32'h0000_0001);
        repeat (20) @(posedge MCLK);
        chk("warm_hold", cnv_cnt, c);
      end
      wait_cnv(c);
      chk("level", lvl, d);
      chk("core_on", core_on, 1'b1);
      chk("int_out", int_ok, 1'b1);
    end
    // buffer and sleep behaviour per control setting
    for (int k = 0; k < 3; k++) begin
      cv = (k == 0) ? 8'h41 : (k == 1) ? 8'h01 : 8'hC1;
      wb(1'b1, DACCTL_OFS_CTRL, {24'h0, cv});
      wb(1'b0, DACCTL_OFS_CTRL, 32'h0);
      chk("ctrl_rb", rd[7:0], cv);
      repeat (3) @(posedge MCLK);
      chk("buf", buf_on, cv[6]);
      if (cv[6]) chk("pin", pin, lvl);
      sb <= 1'b1;
      repeat (8) @(posedge MCLK);
      chk("stby_core", core_on, cv[7]);
      chk("stby_buf", buf_on, cv[7] & cv[6]);
      sb <= 1'b0;
      repeat (8) @(posedge MCLK);
      chk("wake_core", core_on, 1'b1);
      chk("wake_buf", buf_on, cv[6]);
      pd <= 1'b1;
      repeat (8) @(posedge MCLK);
      chk("pd_core", core_on, 1'b0);
      chk("pd_buf", buf_on, 1'b0);
      pd <= 1'b0;
      repeat (8) @(posedge MCLK);
    end
    wb(1'b1, DACCTL_OFS_CTRL, 32'h0);
    repeat (3) @(posedge MCLK);
    chk("core_off", core_on, 1'b0);
    // a reset during warm-up clears control, data and the core
    wb(1'b1, DACCTL_OFS_CTRL, 32'h0000_0041);
    repeat (3) @(posedge MCLK);
    chk("pre_rst_core", core_on, 1'b1);
    RST_N <= 1'b0;
    @(posedge MCLK);
    chk("rst_core", core_on, 1'b0);
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    wb(1'b0, DACCTL_OFS_CTRL, 32'h0);
    chk("rst_ctrl", rd, 32'h0);
    wb(1'b0, DACCTL_OFS_DATA_H, 32'h0);
    chk("rst_data", rd, 32'h0);
    wrap_up();
  end
endmodule
